// ==== rtl/tmr_pkg.sv ====
// Constants, field layout and types of the 8-bit compare timer block.
// Assumes a single 40 MHz pclk domain and an APB register slave.
// Function
// - A nonzero compare output mode routes the compare output onto the pin.
// - Non-PWM: 00 off, 01 toggle, 10 clear, 11 set on match.
// - Fast PWM: 10 clears on match sets at BOTTOM, 11 inverse.
// - Fast PWM with compare at TOP and high bit set ignores the match.
// - Phase-correct: 10 clears on up match, sets on down match; 11 inverse.
// - Phase-correct with compare at TOP: action happens at TOP instead.
// - Clock select 0 stops; 1..7 divide source by 1,8,32,64,128,256,1024.
// - Counter register gives direct read and write access to the counter.
// - A counter write blocks the compare match on the next timer tick.
// - Compare value checked against counter every tick; equality is a match.
// - Async select 0 clocks from pclk, 1 from oscillator input pin.
// - Counter, compare and control contents are not guaranteed after async switch.
// - Async counter write sets its busy flag until the value is transferred.
// - Async compare write sets its busy flag until the value is transferred.
// - Waveform modes normal, phase PWM, clear-on-compare, fast PWM; TOP 0xFF except mode 2.
// - Async writes sit in a holding register, loaded after two oscillator edges.
// - Async control write sets its busy flag until the value is transferred.
package tmr_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_ASYNC_STATUS = 8'h30;
  localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h34;
  localparam logic [7:0] ADDR_COUNTER_VALUE = 8'h38;
  localparam logic [7:0] ADDR_COMPARE_VALUE = 8'h3C;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h40;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h44;

  // ---------------------------------------------------------------
  // Fields
  // ---------------------------------------------------------------
  localparam int CTL_CS_LSB = 0;
  localparam int CTL_WAVE_HI_BIT = 3;
  localparam int CTL_COM_LSB = 4;
  localparam int CTL_WAVE_LO_BIT = 6;
  localparam logic [7:0] CTL_WRITE_MASK = 8'h7F;
  localparam int ASYNC_SEL_BIT = 3;
  localparam int BUSY_CONTROL = 0;
  localparam int BUSY_COMPARE = 1;
  localparam int BUSY_COUNTER = 2;
  localparam int IRQ_MATCH = 0;
  localparam int IRQ_OVERFLOW = 1;

  // ---------------------------------------------------------------
  // Values
  // ---------------------------------------------------------------
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] TOP_MAX = 8'hFF;
  localparam logic [7:0] BOTTOM = 8'h00;
  localparam logic [1:0] XFER_EDGES = 2'h2;

  typedef enum logic [1:0] {
    WAVE_NORMAL = 2'h0,
    WAVE_PHASE = 2'h1,
    WAVE_CTC = 2'h2,
    WAVE_FAST = 2'h3
  } tmr_wave_e;

endpackage : tmr_pkg

// ==== rtl/tmr_osc_edge.sv ====
// Rising-edge detector for the timer oscillator input pin.
// Assumes the pin is already synchronous to pclk.
`timescale 1ns/1ps
module tmr_osc_edge
  import tmr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic osc_in,
  output logic osc_rise
);

  typedef struct packed {
    logic prev;
  } tmr_edge_s;

  tmr_edge_s s;
  tmr_edge_s next_s;

  always_comb
  begin
    next_s = s;
    next_s.prev = osc_in;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s <= '0;
    else
      s <= next_s;
  end

  assign osc_rise = osc_in & ~s.prev;

endmodule : tmr_osc_edge

// ==== rtl/tmr_prescaler.sv ====
// Prescaler turning source ticks into timer ticks.
// Assumes src_tick is a one-cycle enable in the pclk domain.
`timescale 1ns/1ps
module tmr_prescaler
  import tmr_pkg::*;
#(
  parameter int CNT_W = 10
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic src_tick,
  input wire logic [2:0] clock_select,
  output logic tick
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } tmr_pre_s;

  tmr_pre_s s;
  tmr_pre_s next_s;

  function automatic logic [CNT_W-1:0] last_count(input logic [2:0] sel);
    case (sel)
      3'h2: last_count = CNT_W'(7);
      3'h3: last_count = CNT_W'(31);
      3'h4: last_count = CNT_W'(63);
      3'h5: last_count = CNT_W'(127);
      3'h6: last_count = CNT_W'(255);
      3'h7: last_count = CNT_W'(1023);
      default: last_count = '0;
    endcase
  endfunction : last_count

  // A stopped timer keeps its prescaler cleared, so a restart gives a full first period.
  assign tick = src_tick && (clock_select != 3'h0) && (s.cnt == last_count(clock_select));

  always_comb
  begin
    next_s = s;
    if (clock_select == 3'h0)
      next_s.cnt = '0;
    else if (tick)
      next_s.cnt = '0;
    else if (src_tick)
      next_s.cnt = s.cnt + CNT_W'(1);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s <= '0;
    else
      s <= next_s;
  end

endmodule : tmr_prescaler

// ==== rtl/tmr_timer.sv ====
// 8-bit compare timer with PWM output, prescaler and asynchronous clock option.
// Assumes an APB master on pclk and pin inputs synchronous to pclk.
`timescale 1ns/1ps
module tmr_timer
  import tmr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_osc_input_pin,
  input wire logic port_out_value,
  input wire logic port_direction,
  output logic compare_output_pin,
  output logic compare_output_pin_oe_n,
  output logic irq
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] ctl_tmp;
    logic [7:0] cnt;
    logic [7:0] cnt_tmp;
    logic [7:0] cmp;
    logic [7:0] cmp_tmp;
    logic async_sel;
    logic [2:0] busy;
    logic [2:0][1:0] xfer;
    logic block;
    logic down;
    logic oc;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [31:0] rdata;
    logic slverr;
  } tmr_state_s;

  tmr_state_s s;
  tmr_state_s next_s;

  logic osc_rise;
  logic tick;
  logic src_tick;
  tmr_wave_e wave;
  logic [1:0] com;
  logic [7:0] top;
  logic match;
  logic up;
  logic wr;
  logic [1:0] irq_set;
  logic [1:0] irq_clr;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // One counter step in the given direction; it wraps modulo 256 on purpose.
  function automatic logic [7:0] count_step(input logic [7:0] value, input logic dec);
    if (dec)
      count_step = value - 8'h01;
    else
      count_step = value + 8'h01;
  endfunction : count_step

  // Level left by a compare event in a PWM mode; mode 01 is reserved and keeps the level.
  function automatic logic pwm_level(input logic [1:0] mode, input logic up_match, input logic level);
    if (!mode[1])
      pwm_level = level;
    else if (up_match)
      pwm_level = mode[0];
    else
      pwm_level = ~mode[0];
  endfunction : pwm_level

  // True on the count that the last oscillator edge of a transfer finds.
  function automatic logic xfer_last(input logic [1:0] count);
    xfer_last = (count == XFER_EDGES - 2'h1);
  endfunction : xfer_last

  // Registers are one byte wide; the upper bits of a read word are zero.
  function automatic logic [31:0] byte_word(input logic [7:0] value);
    byte_word = {24'h00_0000, value};
  endfunction : byte_word

  // ---------------------------------------------------------------
  // Clock source and prescaler
  // ---------------------------------------------------------------
  tmr_osc_edge u_osc_edge (
    .pclk(pclk),
    .presetn(presetn),
    .osc_in(timer_osc_input_pin),
    .osc_rise(osc_rise)
  );

  // With async select set the oscillator edge is the source tick, so the pin must run far slower than pclk.
  assign src_tick = s.async_sel ? osc_rise : 1'b1;

  tmr_prescaler #(.CNT_W(10)) u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .src_tick(src_tick),
    .clock_select(s.ctl[CTL_CS_LSB +: 3]),
    .tick(tick)
  );

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  assign wave = tmr_wave_e'({s.ctl[CTL_WAVE_HI_BIT], s.ctl[CTL_WAVE_LO_BIT]});
  assign com = s.ctl[CTL_COM_LSB +: 2];
  assign top = (wave == WAVE_CTC) ? s.cmp : TOP_MAX;
  assign match = tick && (s.cnt == s.cmp) && !s.block;
  // The bottom sample counts as up-going so a compare of zero holds the output steady.
  assign up = (!s.down && (s.cnt != TOP_MAX)) || (s.cnt == BOTTOM);
  assign wr = psel && penable && pwrite;

  always_comb
  begin
    next_s = s;
    irq_set = 2'h0;
    irq_clr = 2'h0;

    // ---------------------------------------------------------------
    // Counter
    // ---------------------------------------------------------------
    if (tick)
    begin
      next_s.block = 1'b0;
      if (wave == WAVE_PHASE)
      begin
        if (!s.down)
        begin
          if (s.cnt == TOP_MAX)
          begin
            next_s.down = 1'b1;
            next_s.cnt = count_step(s.cnt, 1'b1);
          end
          else
            next_s.cnt = count_step(s.cnt, 1'b0);
        end
        else if (s.cnt == BOTTOM)
        begin
          next_s.down = 1'b0;
          next_s.cnt = count_step(s.cnt, 1'b0);
          irq_set[IRQ_OVERFLOW] = 1'b1;
        end
        else
          next_s.cnt = count_step(s.cnt, 1'b1);
      end
      else
      begin
        next_s.down = 1'b0;
        if (s.cnt == TOP_MAX)
          irq_set[IRQ_OVERFLOW] = 1'b1;
        if (s.cnt == top)
          next_s.cnt = BOTTOM;
        else
          next_s.cnt = count_step(s.cnt, 1'b0);
      end
    end

    if (match)
      irq_set[IRQ_MATCH] = 1'b1;

    // ---------------------------------------------------------------
    // Compare output
    // ---------------------------------------------------------------
    unique case (wave)
      WAVE_NORMAL, WAVE_CTC:
      begin
        if (match)
        begin
          unique case (com)
            2'h1: next_s.oc = ~s.oc;
            2'h2: next_s.oc = 1'b0;
            2'h3: next_s.oc = 1'b1;
            default: next_s.oc = s.oc;
          endcase
        end
      end
      WAVE_FAST:
      begin
        if (com[1] && tick)
        begin
          if (s.cnt == TOP_MAX)
            next_s.oc = pwm_level(com, 1'b0, s.oc);
          else if (match && (s.cmp != TOP_MAX))
            next_s.oc = pwm_level(com, 1'b1, s.oc);
        end
      end
      WAVE_PHASE:
      begin
        if (com[1] && tick)
        begin
          if (s.cmp == TOP_MAX)
          begin
            if (s.cnt == TOP_MAX)
              next_s.oc = pwm_level(com, 1'b0, s.oc);
          end
          else if (match)
            next_s.oc = pwm_level(com, up, s.oc);
        end
      end
    endcase

    // ---------------------------------------------------------------
    // Holding register transfers
    // ---------------------------------------------------------------
    for (int i = 0; i < 3; i++)
    begin
      if (s.busy[i] && osc_rise)
      begin
        if (xfer_last(s.xfer[i]))
        begin
          next_s.busy[i] = 1'b0;
          next_s.xfer[i] = 2'h0;
        end
        else
          next_s.xfer[i] = s.xfer[i] + 2'h1;
      end
    end
    if (s.busy[BUSY_CONTROL] && !next_s.busy[BUSY_CONTROL])
      next_s.ctl = s.ctl_tmp;
    if (s.busy[BUSY_COMPARE] && !next_s.busy[BUSY_COMPARE])
      next_s.cmp = s.cmp_tmp;
    if (s.busy[BUSY_COUNTER] && !next_s.busy[BUSY_COUNTER])
    begin
      next_s.cnt = s.cnt_tmp;
      next_s.block = 1'b1;
    end

    // ---------------------------------------------------------------
    // Register writes
    // ---------------------------------------------------------------
    // A rewrite while busy restarts the transfer; software must avoid it.
    if (wr)
    begin
      unique case (paddr)
        ADDR_ASYNC_STATUS:
        begin
          next_s.async_sel = pwdata[ASYNC_SEL_BIT];
          if (pwdata[ASYNC_SEL_BIT] != s.async_sel)
          begin
            // Pending transfers are dropped on a clock switch.
            next_s.busy = 3'h0;
            next_s.xfer = '0;
          end
        end
        ADDR_TIMER_CONTROL:
        begin
          next_s.ctl_tmp = pwdata[7:0] & CTL_WRITE_MASK;
          if (s.async_sel)
          begin
            next_s.busy[BUSY_CONTROL] = 1'b1;
            next_s.xfer[BUSY_CONTROL] = 2'h0;
          end
          else
            next_s.ctl = pwdata[7:0] & CTL_WRITE_MASK;
        end
        ADDR_COUNTER_VALUE:
        begin
          next_s.cnt_tmp = pwdata[7:0];
          if (s.async_sel)
          begin
            next_s.busy[BUSY_COUNTER] = 1'b1;
            next_s.xfer[BUSY_COUNTER] = 2'h0;
          end
          else
          begin
            next_s.cnt = pwdata[7:0];
            next_s.block = 1'b1;
          end
        end
        ADDR_COMPARE_VALUE:
        begin
          next_s.cmp_tmp = pwdata[7:0];
          if (s.async_sel)
          begin
            next_s.busy[BUSY_COMPARE] = 1'b1;
            next_s.xfer[BUSY_COMPARE] = 2'h0;
          end
          else
            next_s.cmp = pwdata[7:0];
        end
        ADDR_IRQ_STATUS: irq_clr = pwdata[1:0];
        ADDR_IRQ_MASK: next_s.irq_mask = pwdata[1:0];
        default: next_s.irq_mask = s.irq_mask;
      endcase
    end

    // ---------------------------------------------------------------
    // Interrupt flags
    // ---------------------------------------------------------------
    // An event in the clearing cycle still sets its bit.
    next_s.irq_status = (s.irq_status & ~irq_clr) | irq_set;

    // ---------------------------------------------------------------
    // Read data, captured in the setup cycle
    // ---------------------------------------------------------------
    if (psel && !penable)
    begin
      next_s.rdata = 32'h0000_0000;
      next_s.slverr = 1'b0;
      unique case (paddr)
        ADDR_ASYNC_STATUS: next_s.rdata[3:0] = {s.async_sel, s.busy};
        ADDR_TIMER_CONTROL: next_s.rdata = byte_word(s.ctl_tmp);
        ADDR_COUNTER_VALUE: next_s.rdata = byte_word(s.cnt);
        ADDR_COMPARE_VALUE: next_s.rdata = byte_word(s.cmp_tmp);
        ADDR_IRQ_STATUS: next_s.rdata[1:0] = s.irq_status;
        ADDR_IRQ_MASK: next_s.rdata[1:0] = s.irq_mask;
        default: next_s.slverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s <= '0;
    else
      s <= next_s;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign prdata = s.rdata;
  assign pready = 1'b1;
  assign pslverr = s.slverr && psel && penable;
  assign compare_output_pin = (com != 2'h0) ? s.oc : port_out_value;
  assign compare_output_pin_oe_n = ~port_direction;
  assign irq = |(s.irq_status & s.irq_mask);

endmodule : tmr_timer

// ==== testbench/tmr_timer_properties.sv ====
// Concurrent checks on the compare timer ports.
// Assumes a bind into tmr_timer; the control and counter shadows are trusted in synchronous mode only.
`timescale 1ns/1ps
module tmr_timer_chk
  import tmr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic timer_osc_input_pin,
  input wire logic port_out_value,
  input wire logic port_direction,
  input wire logic compare_output_pin,
  input wire logic compare_output_pin_oe_n,
  input wire logic irq
);
  // ----------------------------------------------------------
  // Shadow registers
  // ----------------------------------------------------------
  // An async switch may corrupt the registers, so taint turns the control and counter shadow checks off until reset.
  logic wr;
  logic rd;
  logic taint;
  logic moved;
  logic [7:0] ctl;
  logic [7:0] msk;
  logic [7:0] cnt;
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctl <= 8'h00;
      msk <= 8'h00;
      cnt <= 8'h00;
      taint <= 1'b0;
      moved <= 1'b0;
    end
    else
    begin
      if (wr && paddr == ADDR_TIMER_CONTROL)
        ctl <= pwdata[7:0];
      if (wr && paddr == ADDR_IRQ_MASK)
        msk <= pwdata[7:0];
      if (wr && paddr == ADDR_ASYNC_STATUS && pwdata[ASYNC_SEL_BIT])
        taint <= 1'b1;
      if (wr && paddr == ADDR_COUNTER_VALUE)
        cnt <= pwdata[7:0];
      if (wr && paddr == ADDR_COUNTER_VALUE)
        moved <= ctl[2:0] != 3'h0;
      else if (ctl[2:0] != 3'h0)
        moved <= 1'b1;
    end
  end
  // ----------------------------------------------------------
  // Properties
  // ----------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Three stopped cycles are needed because a tick launched before the stop may still land.
  sequence s_stopped;
    !taint && ctl[5:4] != 2'h0 && ctl[2:0] == 3'h0 && $past(ctl[2:0]) == 3'h0 && $past(ctl[2:0], 2) == 3'h0;
  endsequence
  sequence s_quiet;
    s_stopped ##0 !wr;
  endsequence
  a_oe_direction: assert property (compare_output_pin_oe_n == !port_direction)
    else $error("pin driver enable does not follow the direction bit");
  a_port_passthru: assert property (!taint && ctl[5:4] == 2'h0 |-> compare_output_pin == port_out_value)
    else $error("disconnected output does not show the port value");
  a_stop_holds: assert property (s_quiet |=> $stable(compare_output_pin))
    else $error("output moved while the timer was stopped");
  a_count_direct: assert property (rd && paddr == ADDR_COUNTER_VALUE && !taint && !moved
    |-> prdata[7:0] == cnt) else $error("counter read differs from the value written");
  a_read_upper: assert property (rd |-> prdata[31:8] == 24'h0)
    else $error("upper read data bits are not zero");
  a_sync_idle: assert property (rd && paddr == ADDR_ASYNC_STATUS && !taint |-> prdata[7:0] == 8'h00)
    else $error("status shows busy or async in synchronous mode");
  a_mask_blocks: assert property (msk == 8'h00 && $past(msk) == 8'h00 |-> !irq)
    else $error("interrupt raised with every source masked");
  a_reset_clean: assert property ($rose(presetn) |-> !irq && prdata == 32'h0)
    else $error("outputs not cleared by reset");
endmodule : tmr_timer_chk

bind tmr_timer tmr_timer_chk tmr_timer_chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timer_osc_input_pin(timer_osc_input_pin), .port_out_value(port_out_value),
  .port_direction(port_direction), .compare_output_pin(compare_output_pin),
  .compare_output_pin_oe_n(compare_output_pin_oe_n), .irq(irq)
);

// ==== testbench/tb_top.sv ====
// Self-checking bench for the compare timer block.
// Assumes tmr_timer with a zero-wait APB slave and the bound checker.
`timescale 1ns/1ps
module tb_top;
  import tmr_pkg::*;
  localparam int DIV [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
  logic pclk, presetn, psel, penable, pwrite, osc, pov, pdir, pready, pslverr, pin, pin_oe_n, irq, err;
  logic [7:0] paddr;
  logic [7:0] c0;
  logic [31:0] pwdata, prdata, q;
  int bad_count, check_count;
  tmr_timer tmr_timer_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_osc_input_pin(osc), .port_out_value(pov), .port_direction(pdir),
    .compare_output_pin(pin), .compare_output_pin_oe_n(pin_oe_n), .irq(irq));
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // ----------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    apb(1'b0, a, 8'h00);
    chk(n, q, {24'h0, e});
  endtask : rd
  function automatic logic [7:0] ctl(input logic [1:0] w, input logic [1:0] m, input logic [2:0] s);
    ctl = {1'b0, w[0], m, w[1], s};
  endfunction : ctl
  task automatic osc_rise();
    @(posedge pclk);
    osc <= 1'b1;
    cyc(4);
    osc <= 1'b0;
    cyc(4);
  endtask : osc_rise
  task automatic pwm(input logic [1:0] w, input logic [7:0] c, input logic [1:0] m, input int t1, input int t2,
                     input logic e1, input logic e2);
    // A phase run may stop while counting down; a short normal run restores the up direction.
    wr(ADDR_TIMER_CONTROL, ctl(WAVE_NORMAL, 2'h0, 3'h1));
    wr(ADDR_TIMER_CONTROL, ctl(w, m, 3'h0));
    wr(ADDR_COMPARE_VALUE, c);
    wr(ADDR_COUNTER_VALUE, 8'h20);
    wr(ADDR_TIMER_CONTROL, ctl(w, m, 3'h1));
    cyc(t1);
    chk("pwm_early", 32'(pin), 32'(e1));
    cyc(t2 - t1);
    chk("pwm_late", 32'(pin), 32'(e2));
  endtask : pwm
  task automatic done(input string n);
    $display("test %s finished, %0d checks so far", n, check_count);
  endtask : done
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test
  // ----------------------------------------------------------
  // Tests
  // ----------------------------------------------------------
  // The limit is about twice the expected run, so a slow but correct design still passes.
  initial
  begin
    cyc(40000);
    bad_count++;
    stop_test();
  end
  initial
  begin
    {presetn, psel, penable, pwrite, osc, pov, pdir} = 7'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    bad_count = 0;
    check_count = 0;
    cyc(10);
    presetn <= 1'b1;
    for (int a = 8'h30; a <= 8'h44; a += 4)
      rd(8'(a), 8'h00, "reset_value");
    wr(8'h50, 8'hFF);
    chk("unmapped_write", 32'(err), 32'h1);
    chk("ready_high", 32'(pready), 32'h1);
    rd(8'h50, 8'h00, "unmapped_read");
    chk("unmapped_read_err", 32'(err), 32'h1);
    done("reset");
    wr(ADDR_TIMER_CONTROL, 8'hFF);
    rd(ADDR_TIMER_CONTROL, CTL_WRITE_MASK, "control_rw");
    wr(ADDR_TIMER_CONTROL, 8'h00);
    wr(ADDR_COUNTER_VALUE, 8'hA5);
    rd(ADDR_COUNTER_VALUE, 8'hA5, "counter_rw");
    wr(ADDR_COMPARE_VALUE, 8'h5A);
    rd(ADDR_COMPARE_VALUE, 8'h5A, "compare_rw");
    for (int i = 0; i < 4; i++)
    begin
      pov <= i[0];
      pdir <= i[1];
      cyc(2);
      chk("port_value", 32'(pin), 32'(i[0]));
      chk("driver_enable", 32'(pin_oe_n), 32'(!i[1]));
    end
    done("registers");
    wr(ADDR_COMPARE_VALUE, 8'h10);
    for (int m = 3; m > 0; m--)
    begin
      wr(ADDR_COUNTER_VALUE, 8'h08);
      wr(ADDR_TIMER_CONTROL, ctl(WAVE_NORMAL, m[1:0], 3'h1));
      cyc(20);
      wr(ADDR_TIMER_CONTROL, ctl(WAVE_NORMAL, m[1:0], 3'h0));
      chk("normal_action", 32'(pin), 32'(m != 2));
    end
    rd(ADDR_IRQ_STATUS, 8'h01, "match_flag");
    wr(ADDR_IRQ_MASK, 8'h01);
    cyc(2);
    chk("irq_raised", 32'(irq), 32'h1);
    wr(ADDR_IRQ_MASK, 8'h00);
    cyc(2);
    chk("irq_masked", 32'(irq), 32'h0);
    wr(ADDR_IRQ_MASK, 8'h01);
    wr(ADDR_IRQ_STATUS, 8'h01);
    cyc(2);
    chk("irq_cleared", 32'(irq), 32'h0);
    wr(ADDR_COUNTER_VALUE, 8'h10);
    wr(ADDR_TIMER_CONTROL, ctl(WAVE_NORMAL, 2'h2, 3'h1));
    cyc(6);
    wr(ADDR_TIMER_CONTROL, 8'h00);
    chk("match_blocked", 32'(pin), 32'h1);
    rd(ADDR_IRQ_STATUS, 8'h00, "blocked_flag");
    wr(ADDR_COMPARE_VALUE, 8'h30);
    wr(ADDR_TIMER_CONTROL, ctl(WAVE_CTC, 2'h0, 3'h1));
    cyc(300);
    wr(ADDR_TIMER_CONTROL, 8'h00);
    apb(1'b0, ADDR_COUNTER_VALUE, 8'h00);
    chk("ctc_top", 32'(q[7:0] <= 8'h30), 32'h1);
    rd(ADDR_IRQ_STATUS, 8'h01, "ctc_no_overflow");
    wr(ADDR_IRQ_STATUS, 8'h03);
    done("compare");
    for (int s = 2; s < 8; s++)
    begin
      wr(ADDR_COUNTER_VALUE, 8'h00);
      wr(ADDR_TIMER_CONTROL, ctl(WAVE_NORMAL, 2'h0, s[2:0]));
      cyc(10 * DIV[s] + DIV[s] / 4);
      wr(ADDR_TIMER_CONTROL, 8'h00);
      rd(ADDR_COUNTER_VALUE, 8'h0A, "prescale_count");
    end
    cyc(50);
    rd(ADDR_COUNTER_VALUE, 8'h0A, "stopped_count");
    done("prescaler");
    pwm(WAVE_FAST, 8'h10, 2'h2, 232, 272, 1'b1, 1'b0);
    pwm(WAVE_FAST, 8'h10, 2'h3, 232, 272, 1'b0, 1'b1);
    pwm(WAVE_FAST, 8'hFF, 2'h2, 232, 272, 1'b1, 1'b1);
    pwm(WAVE_FAST, 8'hFF, 2'h3, 232, 272, 1'b0, 1'b0);
    pwm(WAVE_PHASE, 8'h80, 2'h2, 240, 400, 1'b0, 1'b1);
    pwm(WAVE_PHASE, 8'h80, 2'h3, 240, 400, 1'b1, 1'b0);
    pwm(WAVE_PHASE, 8'hFF, 2'h2, 240, 400, 1'b1, 1'b1);
    pwm(WAVE_PHASE, 8'hFF, 2'h3, 240, 400, 1'b0, 1'b0);
    wr(ADDR_TIMER_CONTROL, 8'h00);
    done("pwm");
    wr(ADDR_ASYNC_STATUS, 8'h08);
    rd(ADDR_ASYNC_STATUS, 8'h08, "async_select");
    wr(ADDR_COUNTER_VALUE, 8'h33);
    rd(ADDR_ASYNC_STATUS, 8'h0C, "counter_busy");
    wr(ADDR_COMPARE_VALUE, 8'h44);
    wr(ADDR_TIMER_CONTROL, ctl(WAVE_NORMAL, 2'h0, 3'h1));
    rd(ADDR_ASYNC_STATUS, 8'h0F, "all_busy");
    osc_rise();
    rd(ADDR_ASYNC_STATUS, 8'h0F, "one_edge_busy");
    osc_rise();
    rd(ADDR_ASYNC_STATUS, 8'h08, "transferred");
    apb(1'b0, ADDR_COUNTER_VALUE, 8'h00);
    c0 = q[7:0];
    repeat (3) osc_rise();
    rd(ADDR_COUNTER_VALUE, c0 + 8'h03, "osc_counting");
    done("async");
    @(posedge pclk);
    presetn <= 1'b0;
    cyc(2);
    presetn <= 1'b1;
    rd(ADDR_ASYNC_STATUS, 8'h00, "second_reset");
    rd(ADDR_TIMER_CONTROL, 8'h00, "second_reset_ctl");
    done("second_reset");
    stop_test();
  end
endmodule : tb_top
